// >>> design/cpa_pkg.sv
// constants and types shared by both ends of the configuration port link
package cpa_pkg;
  // ---------------------------------------------------------------
  // i/o port map and keys
  // ---------------------------------------------------------------
  localparam logic [15:0] CPA_BASE_STRAP0 = 16'h03f0;  // strap low base
  localparam logic [15:0] CPA_BASE_STRAP1 = 16'h0370;  // strap high base
  localparam logic [15:0] CPA_DATA_STEP   = 16'h0001;  // data port above index
  localparam logic [7:0]  CPA_KEY_ENTER   = 8'h55;     // enter key byte
  localparam logic [7:0]  CPA_KEY_EXIT    = 8'haa;     // exit key byte
  localparam logic [7:0]  CPA_UNCLAIMED   = 8'hff;     // undecoded read value
  // ---------------------------------------------------------------
  // configuration register file
  // ---------------------------------------------------------------
  localparam int          CPA_NUM_REGS    = 48;        // indices 00..2f
  localparam logic [7:0]  CPA_LAST_INDEX  = 8'h2f;     // highest index
  localparam logic [5:0]  CPA_IDX_BASE_LO = 6'h12;     // base address [7:1]
  localparam logic [5:0]  CPA_IDX_BASE_HI = 6'h13;     // base address [10:8]
  localparam logic [7:0]  CPA_REG_DEFAULT = 8'h00;     // power-up contents
  localparam logic [7:0]  CPA_LO_MASK     = 8'hfe;     // bit 0 reads zero
  localparam logic [7:0]  CPA_HI_MASK     = 8'h07;     // bits 7:3 read zero
  // ---------------------------------------------------------------
  // host apb register map and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] CPA_OFS_CMD     = 12'h000;   // command
  localparam logic [11:0] CPA_OFS_STATUS  = 12'h004;   // status
  localparam logic [11:0] CPA_OFS_RDATA   = 12'h008;   // read result
  localparam int          CPA_CMD_ADDR_LSB = 0;        // i/o address [15:0]
  localparam int          CPA_CMD_DATA_LSB = 16;       // write byte [23:16]
  localparam int          CPA_CMD_WR_BIT   = 24;       // 1 write, 0 read
  localparam int          CPA_ST_BUSY_BIT  = 0;        // cycle in progress
  localparam int          CPA_RD_CLAIM_BIT = 8;        // read was decoded
  localparam logic [31:0] CPA_ZERO32      = 32'h0000_0000;
  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CPA_RUN    = 2'b01,
    CPA_CONFIG = 2'b10
  } cpa_cfg_state_t;
  typedef enum logic [2:0] {
    CPA_H_IDLE  = 3'b001,
    CPA_H_ISSUE = 3'b010,
    CPA_H_WAIT  = 3'b100
  } cpa_host_state_t;
endpackage

// >>> design/cpa_io_if.sv
// host i/o port cycle link between the host end and the device end
`timescale 1ns/1ps
interface cpa_io_if;
  logic [15:0] io_addr;        // port address
  logic [7:0]  io_wdata;       // write byte
  logic        io_wr;          // write strobe, one cycle
  logic        io_rd;          // read strobe, one cycle
  logic [7:0]  io_rdata;       // read byte
  logic        io_rd_ack;      // read answer, one cycle
  logic        io_rd_claimed;  // read was decoded by the device
  modport dev
  (
    input  io_addr, io_wdata, io_wr, io_rd,
    output io_rdata, io_rd_ack, io_rd_claimed
  );
  modport host
  (
    output io_addr, io_wdata, io_wr, io_rd,
    input  io_rdata, io_rd_ack, io_rd_claimed
  );
endinterface

// >>> design/cpa_device.sv
// configuration access ports: key, index and data port decode with register file
// Summary of operation
// R1: strap level caught when hardware reset falls
// R2: strap 0 gives base 3f0, 1 gives 370
// R3: two base registers relocate the ports
// R4: index and data decode only in config
// R5: index port readable only in config
// R6: power up starts in run state
// R7: key 55 written to key port enters config
// R8: index 00..2f then data port reaches register
// R9: config stays until exit byte written or hardware reset held
// R10: byte aa on key port leaves config
// R11: after exit all register access blocked
// R12: functional outputs keep running during config
// R13: index register changes only in config
// R14: host loads index before data access
// R15: power-up defaults, kept over hardware reset except the base pair, reloaded from the strap
// R16: data port sits one above index port
`timescale 1ns/1ps
module cpa_device
  import cpa_pkg::*;
(
  input  wire logic       i_ref_clk,          // 10 mhz clock
  input  wire logic       i_sys_rst,          // power-up reset, async high
  input  wire logic       i_hw_reset,         // hardware reset pin, high
  input  wire logic       i_shared_strap_pin, // base select strap pin
  cpa_io_if.dev           io,                 // host i/o cycles
  output logic            o_config_active,    // configuration state
  output logic            o_base_select_strap,// latched strap level
  output logic [15:0]     o_base_addr,        // current index port address
  output logic [cpa_pkg::CPA_NUM_REGS*8-1:0] o_cfg_regs // register contents
);
  import cpa_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic           hw_s1;          // hardware reset sync stage 1
  logic           hw_s2;          // hardware reset sync stage 2
  logic           hw_s3;          // delayed copy for edge detect
  logic           strap_s1;       // strap sync stage 1
  logic           strap_s2;       // strap sync stage 2
  logic           strap_latched;  // captured strap level
  cpa_cfg_state_t state;          // run or configuration
  cpa_cfg_state_t next_state;     // next state
  logic [7:0]     index_select_reg; // selected register index
  logic [7:0]     cfg_regs [0:CPA_NUM_REGS-1]; // configuration registers
  logic [7:0]     rdata;          // registered read byte
  logic           rd_ack;         // registered read answer
  logic           rd_claimed;     // registered decode flag

  // ---------------------------------------------------------------
  // reset pin and strap synchronisers
  // ---------------------------------------------------------------
  // two stages before any logic reads the pins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hw_s1    <= 1'b0;
      hw_s2    <= 1'b0;
      hw_s3    <= 1'b0;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end
    else
    begin
      hw_s1    <= i_hw_reset;
      hw_s2    <= hw_s1;
      hw_s3    <= hw_s2;
      strap_s1 <= i_shared_strap_pin;
      strap_s2 <= strap_s1;
    end
  end

  // ---------------------------------------------------------------
  // strap capture and base address
  // ---------------------------------------------------------------
  wire            hw_in_reset = hw_s2;           // hardware reset held
  wire            hw_fall     = hw_s3 & ~hw_s2;  // hardware reset released
  wire [15:0]     strap_base  = strap_s2 ? CPA_BASE_STRAP1 : CPA_BASE_STRAP0; // R2
  wire [7:0]      base_lo     = cfg_regs[CPA_IDX_BASE_LO];
  wire [7:0]      base_hi     = cfg_regs[CPA_IDX_BASE_HI];
  // ports follow the two base registers
  wire [15:0]     index_addr  = {5'b00000, base_hi[2:0], base_lo[7:1], 1'b0}; // R3
  wire [15:0]     data_addr   = index_addr + CPA_DATA_STEP; // R16

  // latched strap level, loaded when hardware reset falls
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      strap_latched <= 1'b0;
    else if (hw_fall)
      strap_latched <= strap_s2; // R1
  end

  // ---------------------------------------------------------------
  // port decode
  // ---------------------------------------------------------------
  wire            in_config   = (state == CPA_CONFIG);
  wire            open_bus    = ~hw_in_reset;    // cycles ignored in reset
  wire            hit_base    = open_bus & (io.io_addr == index_addr);
  // index and data ports decode only while configuring
  wire            hit_index   = hit_base & in_config; // R4
  wire            hit_data    = open_bus & in_config & (io.io_addr == data_addr); // R4
  wire            wr_enter    = hit_base & io.io_wr & ~in_config &
                                (io.io_wdata == CPA_KEY_ENTER); // R7
  wire            wr_exit     = hit_index & io.io_wr &
                                (io.io_wdata == CPA_KEY_EXIT); // R10
  wire            wr_index    = hit_index & io.io_wr & ~wr_exit; // R13
  wire            idx_valid   = (index_select_reg <= CPA_LAST_INDEX); // R8
  wire [5:0]      idx         = index_select_reg[5:0];
  // data port writes use the index loaded beforehand
  wire            wr_data     = hit_data & io.io_wr & idx_valid; // R14
  wire            rd_index    = hit_index & io.io_rd; // R5
  wire            rd_data     = hit_data & io.io_rd;
  wire [7:0]      data_value  = idx_valid ? cfg_regs[idx] : CPA_REG_DEFAULT; // R8
  wire [7:0]      wr_mask     = (idx == CPA_IDX_BASE_LO) ? CPA_LO_MASK :
                                (idx == CPA_IDX_BASE_HI) ? CPA_HI_MASK : 8'hff;
  wire [7:0]      next_rdata  = rd_index ? index_select_reg :
                                rd_data  ? data_value : CPA_UNCLAIMED;

  // ---------------------------------------------------------------
  // configuration state machine
  // ---------------------------------------------------------------
  // stays in config across any accesses until the exit byte or a held hardware reset
  always_comb
  begin
    next_state = state;
    case (state)
      CPA_RUN:
        if (wr_enter)
          next_state = CPA_CONFIG; // R7
      CPA_CONFIG:
        if (hw_in_reset | wr_exit)
          next_state = CPA_RUN; // R9 R10
      default:
        next_state = CPA_RUN;
    endcase
  end

  // power up lands in run state
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state <= CPA_RUN; // R6
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------
  // index select register
  // ---------------------------------------------------------------
  // run-state writes cannot reach it
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      index_select_reg <= CPA_REG_DEFAULT;
    else if (wr_index)
      index_select_reg <= io.io_wdata; // R13
  end

  // ---------------------------------------------------------------
  // configuration register file
  // ---------------------------------------------------------------
  // defaults at power up only; a later hardware reset keeps the
  // contents except the base pair, reloaded from the strap
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int k = 0; k < CPA_NUM_REGS; k++)
        cfg_regs[k] <= CPA_REG_DEFAULT; // R15
      cfg_regs[CPA_IDX_BASE_LO] <= CPA_BASE_STRAP0[7:0];
      cfg_regs[CPA_IDX_BASE_HI] <= {5'b00000, CPA_BASE_STRAP0[10:8]};
    end
    else if (hw_fall)
    begin
      cfg_regs[CPA_IDX_BASE_LO] <= strap_base[7:0]; // R1 R2
      cfg_regs[CPA_IDX_BASE_HI] <= {5'b00000, strap_base[10:8]}; // R2
    end
    else if (wr_data)
      cfg_regs[idx] <= io.io_wdata & wr_mask; // R8 R11
  end

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  // every read is answered next cycle; undecoded reads float high
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rdata      <= CPA_UNCLAIMED;
      rd_ack     <= 1'b0;
      rd_claimed <= 1'b0;
    end
    else
    begin
      rdata      <= next_rdata; // R5 R11
      rd_ack     <= io.io_rd;
      rd_claimed <= rd_index | rd_data; // R4
    end
  end

  assign io.io_rdata        = rdata;
  assign io.io_rd_ack       = rd_ack;
  assign io.io_rd_claimed   = rd_claimed;

  // ---------------------------------------------------------------
  // user side outputs
  // ---------------------------------------------------------------
  // register contents stay visible in either state
  genvar g;
  generate
    for (g = 0; g < CPA_NUM_REGS; g++)
    begin : g_out
      assign o_cfg_regs[g*8 +: 8] = cfg_regs[g]; // R12
    end
  endgenerate

  assign o_config_active     = in_config;
  assign o_base_select_strap = strap_latched;
  assign o_base_addr         = index_addr;
endmodule

// >>> design/cpa_host.sv
// host end: apb command registers that issue i/o port cycles to the device
`timescale 1ns/1ps
module cpa_host
  import cpa_pkg::*;
(
  input  wire logic        i_ref_clk,   // 10 mhz clock
  input  wire logic        i_sys_rst,   // async reset, high
  input  wire logic        i_psel,      // apb select
  input  wire logic        i_penable,   // apb enable
  input  wire logic        i_pwrite,    // apb direction
  input  wire logic [11:0] i_paddr,     // apb byte address
  input  wire logic [31:0] i_pwdata,    // apb write data
  output logic      [31:0] o_prdata,    // apb read data
  output logic             o_pready,    // apb ready
  output logic             o_pslverr,   // apb error, always low
  cpa_io_if.host           io           // i/o cycles to the device
);
  import cpa_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  cpa_host_state_t state;      // cycle sequencer
  logic            is_write;   // latched direction
  logic [15:0]     addr;       // latched port address
  logic [7:0]      wdata;      // latched write byte
  logic            wr;         // write strobe
  logic            rd;         // read strobe
  logic [7:0]      rd_byte;    // last read byte
  logic            rd_claim;   // last read decoded
  logic [31:0]     prdata;     // registered apb read data

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire        access   = i_psel & i_penable;
  wire        idle     = (state == CPA_H_IDLE);
  // software orders key, index and data cycles; busy drops writes
  wire        cmd_go   = access & i_pwrite & (i_paddr == CPA_OFS_CMD) & idle; // R7 R8 R10
  wire [31:0] st_word  = {31'd0, ~idle};
  wire [31:0] rd_word  = {23'd0, rd_claim, rd_byte};
  wire [31:0] next_prdata = (i_paddr == CPA_OFS_STATUS) ? st_word :
                            (i_paddr == CPA_OFS_RDATA)  ? rd_word : CPA_ZERO32;

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // one strobe cycle, then for a read wait for the read answer
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state    <= CPA_H_IDLE;
      is_write <= 1'b0;
      addr     <= 16'h0000;
      wdata    <= 8'h00;
      wr       <= 1'b0;
      rd       <= 1'b0;
      rd_byte  <= 8'h00;
      rd_claim <= 1'b0;
    end
    else
    begin
      case (state)
        CPA_H_IDLE:
          if (cmd_go)
          begin
            state    <= CPA_H_ISSUE;
            is_write <= i_pwdata[CPA_CMD_WR_BIT];
            addr     <= i_pwdata[CPA_CMD_ADDR_LSB +: 16];
            wdata    <= i_pwdata[CPA_CMD_DATA_LSB +: 8];
            wr       <= i_pwdata[CPA_CMD_WR_BIT];
            rd       <= ~i_pwdata[CPA_CMD_WR_BIT];
          end
        CPA_H_ISSUE:
        begin
          wr    <= 1'b0;
          rd    <= 1'b0;
          state <= is_write ? CPA_H_IDLE : CPA_H_WAIT;
        end
        CPA_H_WAIT:
          if (io.io_rd_ack)
          begin
            rd_byte  <= io.io_rdata;
            rd_claim <= io.io_rd_claimed;
            state    <= CPA_H_IDLE;
          end
        default:
          state <= CPA_H_IDLE;
      endcase
    end
  end

  // registered apb read data, loaded in the setup cycle
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      prdata <= CPA_ZERO32;
    else if (i_psel & ~i_penable & ~i_pwrite)
      prdata <= next_prdata;
  end

  assign io.io_addr  = addr;
  assign io.io_wdata = wdata;
  assign io.io_wr    = wr;
  assign io.io_rd    = rd;
  assign o_prdata    = prdata;
  assign o_pready    = 1'b1;
  assign o_pslverr   = 1'b0;
endmodule

// >>> verification/cpa_checker.sv
// concurrent checks on the i/o cycle link between host and device
`timescale 1ns/1ps
module cpa_checker
  import cpa_pkg::*;
(
  input wire logic        i_ref_clk,       // clock
  input wire logic        i_sys_rst,       // power-up reset
  input wire logic        i_hw_reset,      // hardware reset pin
  input wire logic [15:0] io_addr,         // port address
  input wire logic [7:0]  io_wdata,        // write byte
  input wire logic        io_wr,           // write strobe
  input wire logic        io_rd,           // read strobe
  input wire logic [7:0]  io_rdata,        // read byte
  input wire logic        io_rd_ack,       // read answer
  input wire logic        io_rd_claimed,   // read decoded
  input wire logic        o_config_active, // config state
  input wire logic [15:0] o_base_addr      // index port address
);
  // ---------------------------------------------
  // helpers and properties
  // ---------------------------------------------
  logic [5:0] hw_hist;
  // quiet once the hardware reset pin has been low a while
  wire quiet  = !i_hw_reset && (hw_hist == 6'h00);
  wire key_wr = io_wr && (io_addr == o_base_addr);
  wire enter  = key_wr && (io_wdata == CPA_KEY_ENTER);
  wire leave  = key_wr && (io_wdata == CPA_KEY_EXIT);
  wire port   = (io_addr == o_base_addr) || (io_addr == o_base_addr + CPA_DATA_STEP);
  // recent history of the hardware reset pin
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst)
      hw_hist <= 6'h00;
    else
      hw_hist <= {hw_hist[4:0], i_hw_reset};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_ack_after_read: assert property (io_rd |=> io_rd_ack)
    else $error("read strobe not answered next cycle");
  a_ack_needs_read: assert property (io_rd_ack |-> $past(io_rd))
    else $error("read answer without a read strobe");
  a_key_enters: assert property (quiet && !o_config_active && enter |=> o_config_active)
    else $error("enter key did not open config");
  a_key_exits: assert property (quiet && o_config_active && leave |=> !o_config_active)
    else $error("exit key did not close config");
  a_config_holds: assert property (quiet && o_config_active && !leave |=> o_config_active)
    else $error("config state dropped without exit key");
  a_run_holds: assert property (!o_config_active && !enter |=> !o_config_active)
    else $error("config state opened without key");
  a_run_silent: assert property (io_rd && !o_config_active
    |=> !io_rd_claimed && (io_rdata == CPA_UNCLAIMED))
    else $error("read decoded in run state");
  a_config_claims: assert property (quiet && o_config_active && io_rd && port
    |=> io_rd_claimed)
    else $error("config port read not decoded");
  a_base_stable: assert property (quiet && !io_wr |=> $stable(o_base_addr))
    else $error("base moved without a write");
  c_enter: cover property (quiet && enter);
  c_claimed: cover property (io_rd_ack && io_rd_claimed);
  c_relocate: cover property (quiet && !$stable(o_base_addr));
endmodule

// >>> verification/tb.sv
// bench driving the host apb side and the device straps and resets
`timescale 1ns/1ps
module tb
  import cpa_pkg::*;
;
  logic                      clk     = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      hw_rst  = 1'b0;
  logic                      strap   = 1'b0;
  logic                      psel    = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite  = 1'b0;
  logic [11:0]               paddr   = 12'h000;
  logic [31:0]               pwdata  = 32'h0000_0000;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      cfg_on;
  logic                      strap_q;
  logic [15:0]               base;
  logic [CPA_NUM_REGS*8-1:0] regs;
  logic [7:0]                rb;
  logic                      cl;
  logic [7:0]                idx [3] = '{8'h00, 8'h05, CPA_LAST_INDEX};
  int                        error_cnt = 0;
  int                        n_tests   = 0;
  int                        cyc       = 0;
  // ---------------------------------------------
  // structure and clock
  // ---------------------------------------------
  cpa_io_if u_cpa_io_if ();
  cpa_host u_cpa_host
  (
    .i_ref_clk (clk), .i_sys_rst (sys_rst), .i_psel (psel), .i_penable (penable),
    .i_pwrite (pwrite), .i_paddr (paddr), .i_pwdata (pwdata), .o_prdata (prdata),
    .o_pready (pready), .o_pslverr (pslverr), .io (u_cpa_io_if.host)
  );
  cpa_device u_cpa_device
  (
    .i_ref_clk (clk), .i_sys_rst (sys_rst), .i_hw_reset (hw_rst),
    .i_shared_strap_pin (strap), .io (u_cpa_io_if.dev), .o_config_active (cfg_on),
    .o_base_select_strap (strap_q), .o_base_addr (base), .o_cfg_regs (regs)
  );
  cpa_checker u_cpa_checker
  (
    .i_ref_clk (clk), .i_sys_rst (sys_rst), .i_hw_reset (hw_rst),
    .io_addr (u_cpa_io_if.io_addr), .io_wdata (u_cpa_io_if.io_wdata),
    .io_wr (u_cpa_io_if.io_wr), .io_rd (u_cpa_io_if.io_rd),
    .io_rdata (u_cpa_io_if.io_rdata), .io_rd_ack (u_cpa_io_if.io_rd_ack),
    .io_rd_claimed (u_cpa_io_if.io_rd_claimed), .o_config_active (cfg_on),
    .o_base_addr (base)
  );
  always #50 clk = ~clk;
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    chk(pslverr, 1'b0, "bus error");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue one i/o cycle, wait for idle, fetch the read result
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    int          k;
    apb(1'b1, CPA_OFS_CMD, {7'h00, wr, d, a}, q);
    k = 0;
    q = 32'h0000_0001;
    while (q[CPA_ST_BUSY_BIT] !== 1'b0 && k < 50)
    begin
      apb(1'b0, CPA_OFS_STATUS, CPA_ZERO32, q);
      k++;
    end
    // a poll that runs out counts as a mismatch
    chk(q[CPA_ST_BUSY_BIT], 1'b0, "host stuck busy");
    apb(1'b0, CPA_OFS_RDATA, CPA_ZERO32, q);
    rb = q[7:0];
    cl = q[CPA_RD_CLAIM_BIT];
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(cfg_on, 1'b0, "run after reset");
    chk(base, CPA_BASE_STRAP0, "base after reset");
    chk(regs[8*5+:8], CPA_REG_DEFAULT, "default");
    io(1'b1, CPA_BASE_STRAP0, 8'h05);
    io(1'b1, CPA_BASE_STRAP0 + CPA_DATA_STEP, 8'h77);
    io(1'b0, CPA_BASE_STRAP0, 8'h00);
    chk({cl, rb}, 9'h0ff, "index read in run");
    chk(regs[7:0], CPA_REG_DEFAULT, "data write in run");
    $display("test run state done");
    io(1'b1, CPA_BASE_STRAP0, CPA_KEY_ENTER);
    chk(cfg_on, 1'b1, "enter");
    io(1'b0, CPA_BASE_STRAP0, 8'h00);
    chk({cl, rb}, 9'h100, "index untouched in run");
    for (int i = 0; i < 3; i++)
    begin
      io(1'b1, base, idx[i]);
      io(1'b1, base + CPA_DATA_STEP, idx[i] ^ 8'h5a);
      io(1'b0, base + CPA_DATA_STEP, 8'h00);
      chk({cl, rb}, {1'b1, idx[i] ^ 8'h5a}, "data read back");
      chk(regs[8*idx[i]+:8], idx[i] ^ 8'h5a, "register contents");
      io(1'b0, base, 8'h00);
      chk({cl, rb}, {1'b1, idx[i]}, "index read");
    end
    io(1'b1, base, 8'h30);
    io(1'b0, base + CPA_DATA_STEP, 8'h00);
    chk({cl, rb}, 9'h100, "index beyond last");
    chk(cfg_on, 1'b1, "config kept");
    $display("test config access done");
    io(1'b1, base, {2'b00, CPA_IDX_BASE_LO});
    io(1'b1, base + CPA_DATA_STEP, 8'he1);
    chk(base, 16'h03e0, "relocated base");
    io(1'b0, CPA_BASE_STRAP0, 8'h00);
    chk({cl, rb}, 9'h0ff, "old base silent");
    io(1'b0, 16'h03e0, 8'h00);
    chk({cl, rb}, {1'b1, 2'b00, CPA_IDX_BASE_LO}, "new base index");
    io(1'b1, 16'h03e0, CPA_KEY_EXIT);
    chk(cfg_on, 1'b0, "exit");
    io(1'b1, 16'h03e1, 8'h99);
    io(1'b0, 16'h03e1, 8'h00);
    chk({cl, rb}, 9'h0ff, "data blocked after exit");
    chk(regs[8*18+:8], 8'he0, "base low kept");
    $display("test relocation done");
    io(1'b1, 16'h03e0, CPA_KEY_ENTER);
    chk(cfg_on, 1'b1, "reenter");
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    hw_rst <= 1'b1;
    repeat (4) @(posedge clk);
    hw_rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(strap_q, 1'b1, "strap latched");
    chk(base, CPA_BASE_STRAP1, "strap base");
    chk(cfg_on, 1'b0, "run after hw reset");
    chk(regs[8*5+:8], 8'h5f, "kept over reset");
    io(1'b1, CPA_BASE_STRAP1, CPA_KEY_ENTER);
    io(1'b1, CPA_BASE_STRAP1, 8'h05);
    io(1'b0, CPA_BASE_STRAP1 + CPA_DATA_STEP, 8'h00);
    chk({cl, rb}, 9'h15f, "data at strap base");
    $display("test hardware reset done");
    tally_and_finish();
  end
endmodule
